// file: rtl/chgotg_regs.vh
/*
 * register map constants for the charger otg and timer control bank.
 * assumes a byte-wide register port on clk_sys with 8-bit addresses.
 */
// ====================================================================
// Overview of operation
// RULE1 - otg voltage: 11-bit code, 2800mV plus 10mV steps
// RULE2 - otg voltage bits 15-11 read zero
// RULE3 - otg current: 7-bit code, 40mA steps, default 4Bh
// RULE4 - bit 7: precharge timer, 0=2h 1=0.5h
// RULE5 - topoff timer select: off, 15, 30, 45 minutes
// RULE6 - trickle timer enable, fixed one hour, default on
// RULE7 - precharge timer enable, default on
// RULE8 - fast charge timer enable, default on
// RULE9 - fast timer length 5, 8, 12, 24 hours
// RULE10 - half speed timers during power management or thermal
// RULE11 - auto discharge on overvoltage, register reset only
// RULE12 - forced discharge, register reset only
// RULE13 - charging enable, default on
// RULE14 - optimizer enable, register reset only
// RULE15 - optimizer force: set only, cleared on start
// RULE16 - high impedance cleared on adapter plug-in
// RULE17 - termination enable default on, bit 0 zero
// RULE18 - register reset restores all defaults
// RULE19 - watchdog expiry restores watchdog-reset fields
// RULE20 - reserved writes ignored, any code accepted
`ifndef CHGOTG_REGS_VH
`define CHGOTG_REGS_VH
// ====================================================================
// offsets
`define CHGOTG_ADDR_VOTG_HI 8'h0B
`define CHGOTG_ADDR_VOTG_LO 8'h0C
`define CHGOTG_ADDR_IOTG 8'h0D
`define CHGOTG_ADDR_TMR 8'h0E
`define CHGOTG_ADDR_CTL 8'h0F
// ====================================================================
// reset values
`define CHGOTG_RST_VOTG 11'h0DC
`define CHGOTG_RST_IOTG 8'h4B
`define CHGOTG_RST_TMR 8'h3D
`define CHGOTG_RST_CTL 8'hA2
// ====================================================================
// masks: bits restored by watchdog expiry
`define CHGOTG_WD_IOTG 8'hFF
`define CHGOTG_WD_TMR 8'hFF
`define CHGOTG_WD_CTL 8'h2A
// writable bits per register
`define CHGOTG_WR_CTL 8'hF6
`define CHGOTG_VOTG_HI_MASK 8'h07
// ====================================================================
// control, otg current and timer register field positions
`define CHGOTG_CTL_AUTODIS 7
`define CHGOTG_CTL_FORCEDIS 6
`define CHGOTG_CTL_CHGEN 5
`define CHGOTG_CTL_ICOEN 4
`define CHGOTG_CTL_ICOFORCE 3
`define CHGOTG_CTL_HIZ 2
`define CHGOTG_CTL_TERM 1
`define CHGOTG_IOTG_PRETMR 7
`define CHGOTG_TMR_HALF 0
`define CHGOTG_TMR_TRI 5
`define CHGOTG_TMR_PRE 4
`define CHGOTG_TMR_FAST 3
// ====================================================================
// otg voltage and current scaling
`define CHGOTG_VOTG_OFS_MV 15'd2800
`define CHGOTG_VOTG_STEP_MV 15'd10
`define CHGOTG_VOTG_MAX_MV 15'd22000
`define CHGOTG_IOTG_STEP_MA 12'd40
`define CHGOTG_IOTG_MIN_MA 12'd160
`define CHGOTG_IOTG_MAX_MA 12'd3360
// setpoints held in reset: default codes through the scaling
`define CHGOTG_RST_MV 15'h1388
`define CHGOTG_RST_MA 12'hBB8
`endif

// file: rtl/chgotg_scale.v
/*
 * scaling of otg codes to millivolt and milliamp setpoints.
 * assumes codes come from registers on the same clock.
 */
`timescale 1ns/1ps
`include "chgotg_regs.vh"
module chgotg_scale (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // codes
    input wire [10:0] volt_code,
    input wire [6:0] curr_code,
    // setpoints
    output reg [14:0] otg_voltage_mv,
    output reg [11:0] otg_current_ma
);
    wire [25:0] v_raw; // offset plus step times code
    wire [18:0] i_raw; // step times code
    assign v_raw = {11'h000, `CHGOTG_VOTG_OFS_MV}
        + volt_code * `CHGOTG_VOTG_STEP_MV;
    assign i_raw = curr_code * `CHGOTG_IOTG_STEP_MA;
    // ================================================================
    // registered, clamped setpoints
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            // same values the scaling gives for the default codes
            otg_voltage_mv <= `CHGOTG_RST_MV;
            otg_current_ma <= `CHGOTG_RST_MA;
        end else begin
            // clamp high at top of range
            if (v_raw > {11'h000, `CHGOTG_VOTG_MAX_MV}) begin
                otg_voltage_mv <= `CHGOTG_VOTG_MAX_MV; // see RULE1
            end else begin
                otg_voltage_mv <= v_raw[14:0]; // see RULE1
            end
            // clamp low at bottom of range
            if (i_raw < {7'h00, `CHGOTG_IOTG_MIN_MA}) begin
                otg_current_ma <= `CHGOTG_IOTG_MIN_MA; // see RULE3
            end else if (i_raw > {7'h00, `CHGOTG_IOTG_MAX_MA}) begin
                // top codes would wrap in twelve bits, so saturate
                otg_current_ma <= `CHGOTG_IOTG_MAX_MA; // see RULE3
            end else begin
                otg_current_ma <= i_raw[11:0]; // see RULE3
            end
        end
    end
endmodule // chgotg_scale

// file: rtl/chgotg_bank.v
/*
 * charger otg, safety timer and main control register bank.
 * assumes a simple byte register port on clk_sys (address, write
 * strobe, write data, read data), and that watchdog expiry, register
 * reset, optimizer start and adapter plug-in arrive as one-cycle
 * pulses from logic on the same clock.
 */
`timescale 1ns/1ps
`include "chgotg_regs.vh"
module chgotg_bank (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // reset sources
    input wire register_reset,
    input wire watchdog_expired,
    // hardware events
    input wire optimizer_started,
    input wire adapter_plugged,
    input wire power_mgmt_active,
    input wire thermal_reg_active,
    // field outputs
    output wire [10:0] otg_voltage_code,
    output wire [14:0] otg_voltage_mv,
    output wire [6:0] otg_current_code,
    output wire [11:0] otg_current_ma,
    output wire precharge_timer_length,
    output wire [1:0] topoff_timer_select,
    output wire trickle_timer_enable,
    output wire precharge_timer_enable,
    output wire fast_timer_enable,
    output wire [1:0] fast_timer_length,
    output wire timer_half_speed_enable,
    output wire timer_slow,
    output wire auto_battery_discharge_enable,
    output wire forced_battery_discharge,
    output wire charging_enable,
    output wire input_optimizer_enable,
    output wire input_optimizer_force_start,
    output wire high_impedance_enable,
    output wire termination_enable
);
    reg [10:0] votg_r; // otg voltage code
    reg [7:0] iotg_r; // otg current and precharge length
    reg [7:0] tmr_r; // safety timer control
    reg [7:0] ctl_r; // main charger control
    reg [7:0] ctl_nxt; // next main control value
    wire wr_hi, wr_lo, wr_iotg, wr_tmr, wr_ctl; // write decodes
    // ================================================================
    // address decode
    assign wr_hi = reg_wr && (reg_addr == `CHGOTG_ADDR_VOTG_HI);
    assign wr_lo = reg_wr && (reg_addr == `CHGOTG_ADDR_VOTG_LO);
    assign wr_iotg = reg_wr && (reg_addr == `CHGOTG_ADDR_IOTG);
    assign wr_tmr = reg_wr && (reg_addr == `CHGOTG_ADDR_TMR);
    assign wr_ctl = reg_wr && (reg_addr == `CHGOTG_ADDR_CTL);
    // ================================================================
    // otg voltage, current and timer registers
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            votg_r <= `CHGOTG_RST_VOTG;
            iotg_r <= `CHGOTG_RST_IOTG;
            tmr_r <= `CHGOTG_RST_TMR;
        end else if (register_reset || watchdog_expired) begin
            // all of these fields return on either source
            votg_r <= `CHGOTG_RST_VOTG; // see RULE2 see RULE18 see RULE19
            iotg_r <= `CHGOTG_RST_IOTG; // see RULE3 see RULE4
            tmr_r <= `CHGOTG_RST_TMR; // see RULE7
        end else begin
            // high byte keeps only the three code bits
            if (wr_hi) begin
                votg_r[10:8] <= reg_wdata[2:0]; // see RULE2 see RULE20
            end
            if (wr_lo) begin
                votg_r[7:0] <= reg_wdata; // see RULE1
            end
            if (wr_iotg) begin
                iotg_r <= reg_wdata; // see RULE3 see RULE4 see RULE20
            end
            if (wr_tmr) begin
                tmr_r <= reg_wdata; // see RULE5 see RULE9
            end
        end
    end
    // ================================================================
    // main control next value
    always @* begin
        ctl_nxt = ctl_r;
        if (wr_ctl) begin
            // force bit: a one sets it, a zero leaves it as it is
            ctl_nxt = (reg_wdata & `CHGOTG_WR_CTL)
                | ((reg_wdata | ctl_r)
                & (8'h01 << `CHGOTG_CTL_ICOFORCE)); // see RULE15
        end
        if (watchdog_expired) begin
            ctl_nxt = (ctl_nxt & ~`CHGOTG_WD_CTL)
                | (`CHGOTG_RST_CTL & `CHGOTG_WD_CTL); // see RULE13
        end
        if (optimizer_started) begin
            ctl_nxt[`CHGOTG_CTL_ICOFORCE] = 1'b0; // see RULE15
        end
        if (adapter_plugged) begin
            ctl_nxt[`CHGOTG_CTL_HIZ] = 1'b0; // see RULE16
        end
        if (register_reset) begin
            ctl_nxt = `CHGOTG_RST_CTL; // see RULE11 see RULE12 see RULE18
        end
    end
    // main control register
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctl_r <= `CHGOTG_RST_CTL;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end
    // ================================================================
    // read mux, unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `CHGOTG_ADDR_VOTG_HI: begin
                reg_rdata = {5'h00, votg_r[10:8]}; // see RULE2
            end
            `CHGOTG_ADDR_VOTG_LO: begin
                reg_rdata = votg_r[7:0];
            end
            `CHGOTG_ADDR_IOTG: begin
                reg_rdata = iotg_r;
            end
            `CHGOTG_ADDR_TMR: begin
                reg_rdata = tmr_r;
            end
            `CHGOTG_ADDR_CTL: begin
                reg_rdata = ctl_r; // see RULE17
            end
            default: begin
                reg_rdata = 8'h00;
            end
        endcase
    end
    // ================================================================
    // field breakout
    assign otg_voltage_code = votg_r;
    assign otg_current_code = iotg_r[6:0];
    assign precharge_timer_length = iotg_r[`CHGOTG_IOTG_PRETMR];
    assign topoff_timer_select = tmr_r[7:6]; // see RULE5
    assign trickle_timer_enable = tmr_r[`CHGOTG_TMR_TRI]; // see RULE6
    assign precharge_timer_enable = tmr_r[`CHGOTG_TMR_PRE]; // see RULE7
    assign fast_timer_enable = tmr_r[`CHGOTG_TMR_FAST]; // see RULE8
    assign fast_timer_length = tmr_r[2:1]; // see RULE9
    assign timer_half_speed_enable = tmr_r[`CHGOTG_TMR_HALF];
    // timers slowed only when enabled and regulation active
    assign timer_slow = timer_half_speed_enable
        && (power_mgmt_active || thermal_reg_active); // see RULE10
    assign auto_battery_discharge_enable = ctl_r[`CHGOTG_CTL_AUTODIS];
    assign forced_battery_discharge = ctl_r[`CHGOTG_CTL_FORCEDIS];
    assign charging_enable = ctl_r[`CHGOTG_CTL_CHGEN]; // see RULE13
    assign input_optimizer_enable = ctl_r[`CHGOTG_CTL_ICOEN]; // see RULE14
    // force has effect only with the optimizer enabled
    assign input_optimizer_force_start = ctl_r[`CHGOTG_CTL_ICOFORCE]
        && input_optimizer_enable; // see RULE15
    assign high_impedance_enable = ctl_r[`CHGOTG_CTL_HIZ];
    assign termination_enable = ctl_r[`CHGOTG_CTL_TERM]; // see RULE17
    // ================================================================
    // setpoint scaling
    chgotg_scale u_scale (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .volt_code(votg_r),
        .curr_code(iotg_r[6:0]),
        .otg_voltage_mv(otg_voltage_mv),
        .otg_current_ma(otg_current_ma)
    );
endmodule // chgotg_bank

// file: verification/chgotg_bank_assertions.sv
/* checker for the charger otg and timer control bank.
   assumes a bind onto chgotg_bank, one clock, async low reset. */
`timescale 1ns/1ps
module chgotg_bank_chk (
    // clock, reset, register port and events
    input wire clk_sys, input wire nrst,
    input wire [7:0] reg_addr, input wire reg_wr,
    input wire [7:0] reg_wdata, input wire [7:0] reg_rdata,
    input wire register_reset, input wire watchdog_expired,
    input wire optimizer_started, input wire adapter_plugged,
    input wire power_mgmt_active, input wire thermal_reg_active,
    // field outputs
    input wire [10:0] otg_voltage_code, input wire [14:0] otg_voltage_mv,
    input wire [6:0] otg_current_code, input wire [11:0] otg_current_ma,
    input wire precharge_timer_length, input wire timer_slow,
    input wire timer_half_speed_enable, input wire charging_enable,
    input wire input_optimizer_force_start,
    input wire high_impedance_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ===============================================================
    // defaults shared by watchdog and register reset
    sequence wd_done;
        charging_enable && !input_optimizer_force_start &&
        otg_current_code == 7'h4B && otg_voltage_code == 11'h0DC;
    endsequence
    sequence rr_done;
        wd_done ##0 !high_impedance_enable;
    endsequence
    vsetp_a:
        assert property (otg_voltage_mv == ((32'd2800 + 32'd10 *
            $past(otg_voltage_code) > 32'd22000) ? 32'd22000 :
            32'd2800 + 32'd10 * $past(otg_voltage_code)))
        else $error("otg voltage setpoint wrong");
    isetp_a:
        assert property (otg_current_ma == ((32'd40 *
            $past(otg_current_code) < 32'd160) ? 32'd160 :
            (32'd40 * $past(otg_current_code) > 32'd3360) ? 32'd3360 :
            32'd40 * $past(otg_current_code)))
        else $error("otg current setpoint wrong");
    iotg_wr_a:
        assert property (reg_wr && reg_addr == 8'h0D && !register_reset
            && !watchdog_expired |=> {precharge_timer_length,
            otg_current_code} == $past(reg_wdata))
        else $error("otg current write lost");
    rsv_hi_a:
        assert property (reg_addr == 8'h0B |-> reg_rdata[7:3] == 5'h00)
        else $error("voltage high byte reserved bits set");
    rsv_ctl_a:
        assert property (reg_addr == 8'h0F |-> !reg_rdata[0])
        else $error("control reserved bit set");
    slow_tmr_a:
        assert property (timer_slow == (timer_half_speed_enable &&
            (power_mgmt_active || thermal_reg_active)))
        else $error("timer slowdown wrong");
    wd_dflt_a:
        assert property (watchdog_expired |=> wd_done)
        else $error("watchdog defaults missing");
    rr_dflt_a:
        assert property (register_reset |=> rr_done)
        else $error("register reset defaults missing");
    hiz_clr_a:
        assert property (adapter_plugged |=> !high_impedance_enable)
        else $error("high impedance not cleared");
    force_clr_a:
        assert property (optimizer_started |=> !input_optimizer_force_start)
        else $error("optimizer force not cleared");
endmodule // chgotg_bank_chk
bind chgotg_bank chgotg_bank_chk u_chk (.clk_sys, .nrst, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rdata, .register_reset, .watchdog_expired,
    .optimizer_started, .adapter_plugged, .power_mgmt_active,
    .thermal_reg_active, .otg_voltage_code, .otg_voltage_mv,
    .otg_current_code, .otg_current_ma, .precharge_timer_length,
    .timer_slow, .timer_half_speed_enable, .charging_enable,
    .input_optimizer_force_start, .high_impedance_enable);

// file: verification/chgotg_tb.sv
/* self-checking bench for the charger otg and timer control bank.
   assumes chgotg_bank and its checker are compiled before it. */
`timescale 1ns/1ps
module tb;
    // ===============================================================
    // stimulus, observed outputs and bookkeeping
    reg clk_sys = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg reg_wr = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg [3:0] ev = 4'h0; // register reset, watchdog, opt start, plug
    reg pm = 1'b0;
    reg th = 1'b0;
    reg look = 1'b0; // a noted result is due at this edge
    reg [31:0] rs = 32'hD6F30C50;
    reg [17:0] q [$]; // {select, expected}
    reg [17:0] n;
    reg [7:0] d;
    wire [7:0] reg_rdata;
    wire [14:0] mv;
    wire [11:0] ma;
    wire [7:0] tf; // timer field outputs, packed as the timer register
    wire [7:0] cf; // control field outputs, force gated by enable
    assign cf[0] = 1'b0;
    integer failures = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer i;
    always #5 clk_sys = ~clk_sys;
    chgotg_bank u_chgotg_bank (.clk_sys(clk_sys), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .register_reset(ev[3]),
        .watchdog_expired(ev[2]), .optimizer_started(ev[1]),
        .adapter_plugged(ev[0]), .power_mgmt_active(pm),
        .thermal_reg_active(th), .otg_voltage_code(), .otg_voltage_mv(mv),
        .otg_current_code(), .otg_current_ma(ma),
        .precharge_timer_length(), .topoff_timer_select(tf[7:6]),
        .trickle_timer_enable(tf[5]), .precharge_timer_enable(tf[4]),
        .fast_timer_enable(tf[3]), .fast_timer_length(tf[2:1]),
        .timer_half_speed_enable(tf[0]), .timer_slow(),
        .auto_battery_discharge_enable(cf[7]),
        .forced_battery_discharge(cf[6]),
        .charging_enable(cf[5]), .input_optimizer_enable(cf[4]),
        .input_optimizer_force_start(cf[3]),
        .high_impedance_enable(cf[2]),
        .termination_enable(cf[1]));
    // ===============================================================
    // tasks: lfsr step per cycle, bus cycles, compare, verdict
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task tick;
        @(posedge clk_sys);
        #1;
        rs = lfsr_next(rs);
        pm = rs[3];
        th = rs[9];
    endtask
    task wr(input [7:0] a, input [7:0] v);
        look = 1'b0;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick;
    endtask
    task rd(input [1:0] s, input [7:0] a, input [15:0] e);
        reg_wr = 1'b0;
        reg_addr = a;
        q.push_back({s, e});
        look = 1'b1;
        tick;
    endtask
    task evp(input [3:0] e);
        reg_wr = 1'b0;
        look = 1'b0;
        ev = e;
        tick;
        ev = 4'h0;
    endtask
    task chk(input [15:0] s, input [15:0] e);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task report_and_stop;
        $display("compares %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // monitor: oldest note against register data, a setpoint or the packed field outputs
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (look) begin
            n = q.pop_front();
            case (n[17:16])
                2'h0: chk({8'h00, reg_rdata}, n[15:0]);
                2'h1: chk({1'b0, mv}, n[15:0]);
                2'h2: chk({4'h0, ma}, n[15:0]);
                default: chk({tf, cf}, n[15:0]);
            endcase
        end
        if (cyc == 2000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    // ===============================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        rd(0, 8'h0B, 16'h00);
        rd(0, 8'h0C, 16'hDC);
        rd(0, 8'h0D, 16'h4B);
        rd(0, 8'h0E, 16'h3D);
        rd(0, 8'h0F, 16'hA2);
        rd(0, 8'h20, 16'h00);
        rd(1, 8'h00, 16'd5000);
        rd(2, 8'h00, 16'd3000);
        rd(3, 8'h00, 16'h3DA2);
        for (i = 0; i < 8; i = i + 1) begin
            d = rs[7:0];
            wr(8'h0D, d);
            wr(8'h0B, d);
            rd(0, 8'h0D, {8'h00, d});
            rd(0, 8'h0B, {13'h0000, d[2:0]});
        end
        for (i = 0; i < 4; i = i + 1) begin
            d = {i[1:0], 3'h5, i[1:0], 1'b0};
            wr(8'h0E, d);
            rd(0, 8'h0E, {8'h00, d});
        end
        wr(8'h0B, 8'h07);
        wr(8'h0C, 8'hFF);
        rd(0, 8'h0C, 16'hFF);
        rd(1, 8'h00, 16'd22000);
        wr(8'h0D, 8'h03);
        rd(0, 8'h0D, 16'h03);
        rd(2, 8'h00, 16'd160);
        wr(8'h0D, 8'h54);
        rd(0, 8'h0D, 16'h54);
        rd(2, 8'h00, 16'd3360);
        wr(8'h0F, 8'hFF);
        rd(0, 8'h0F, 16'hFE);
        rd(3, 8'h00, 16'hEEFE);
        wr(8'h0F, 8'h00);
        rd(0, 8'h0F, 16'h08);
        rd(3, 8'h00, 16'hEE00);
        evp(4'h2);
        rd(0, 8'h0F, 16'h00);
        wr(8'h0F, 8'h04);
        evp(4'h1);
        rd(0, 8'h0F, 16'h00);
        wr(8'h0E, 8'h00);
        wr(8'h0F, 8'hDC);
        evp(4'h4);
        rd(0, 8'h0B, 16'h00);
        rd(0, 8'h0E, 16'h3D);
        rd(0, 8'h0F, 16'hF6);
        rd(3, 8'h00, 16'h3DF6);
        wr(8'h0F, 8'h40);
        evp(4'h8);
        rd(0, 8'h0F, 16'hA2);
        ev = 4'h8;
        wr(8'h0D, 8'h11);
        ev = 4'h0;
        rd(0, 8'h0D, 16'h4B);
        evp(4'h0);
        report_and_stop;
    end
endmodule // tb
